//--- verilog/adcc_defs.svh
/*
  offsets, field positions and reset values of the converter control block.
  assumes: included by bare name from the design files.
*/
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// ==========================================================
// register byte offsets
`define ADCC_OFF_RES_LOW   8'h00
`define ADCC_OFF_RES_HIGH  8'h04
`define ADCC_OFF_CTRL_PRI  8'h08
`define ADCC_OFF_CTRL_SEC  8'h0C
`define ADCC_OFF_TS_REF    8'h10
`define ADCC_OFF_TS_EN     8'h14
`define ADCC_OFF_TS_CLK    8'h18
`define ADCC_OFF_TS_INSEL  8'h1C
`define ADCC_OFF_IRQ_STAT  8'h20
`define ADCC_OFF_IRQ_MASK  8'h24
`define ADCC_OFF_PIN_ANA   8'h28
// ==========================================================
// field positions
`define ADCC_BIT_START     7
`define ADCC_BIT_BUSY      6
`define ADCC_BIT_POWER     5
`define ADCC_BIT_JUSTIFY   4
`define ADCC_BIT_SRC_TOP   3
`define ADCC_BIT_AUTO      7
`define ADCC_BIT_TS_EN     7
`define ADCC_BIT_REF_OUT   7
// ==========================================================
// reset values and write masks
`define ADCC_RST_BYTE      8'h00
`define ADCC_RST_TS_REF    8'h40
`define ADCC_WMASK_PRI     8'hBF
`define ADCC_WMASK_SEC     8'hB7
`define ADCC_WMASK_TS_REF  8'hE0
`define ADCC_WMASK_TS_EN   8'hE0
`define ADCC_WMASK_TS_CLK  8'hC3
`define ADCC_WMASK_TS_INS  8'h20
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2
`endif

//--- verilog/adcc_pkg.sv
/*
  types shared by the converter control block.
  assumes: compiled before the modules.
*/
package adcc_pkg;
  typedef enum logic [2:0] {
    ADCC_IDLE   = 3'b001,
    ADCC_LAUNCH = 3'b010,
    ADCC_BUSY   = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

//--- verilog/adcc_clkdiv.sv
/*
  conversion clock divider: one-cycle tick every 2**sel system clocks.
  assumes: sel is a static setting from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv #(
  parameter int SEL_W = 3
) (
  input  wire logic             clk_sys_in,  // system clock
  input  wire logic             resetn_in,   // async reset, active low
  input  wire logic             run_in,      // divider runs while high
  input  wire logic [SEL_W-1:0] sel_in,      // divide by 2**sel
  output logic                  tick_out     // one-cycle tick
);
  localparam int CW = (1 << SEL_W) - 1;
  logic [CW-1:0] cnt_reg;
  wire  [CW-1:0] limit = CW'((1 << sel_in) - 1);
  wire           wrap  = (cnt_reg >= limit);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_reg  <= (!run_in || wrap) ? '0 : cnt_reg + CW'(1);
      tick_out <= run_in && wrap;
    end
  end
endmodule : adcc_clkdiv
`default_nettype wire

//--- verilog/adcc_top.sv
/*
  converter control and result registers behind an AXI4-Lite slave.
  assumes: conversion core and analog mux on the same clock; core answers
  a start pulse with a one-cycle done pulse carrying the 12-bit result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module adcc_top #(
  parameter int RES_W = 12,
  parameter int NPIN  = 8
) (
  input  wire logic             clk_sys_in,        // system clock 100 MHz
  input  wire logic             resetn_in,         // async reset, active low
  input  wire logic [7:0]       s_axi_awaddr,      // write address
  input  wire logic             s_axi_awvalid,     // write address valid
  output logic                  s_axi_awready,     // write address ready
  input  wire logic [31:0]      s_axi_wdata,       // write data
  input  wire logic [3:0]       s_axi_wstrb,       // write strobes
  input  wire logic             s_axi_wvalid,      // write data valid
  output logic                  s_axi_wready,      // write data ready
  output logic [1:0]            s_axi_bresp,       // write response
  output logic                  s_axi_bvalid,      // write response valid
  input  wire logic             s_axi_bready,      // write response ready
  input  wire logic [7:0]       s_axi_araddr,      // read address
  input  wire logic             s_axi_arvalid,     // read address valid
  output logic                  s_axi_arready,     // read address ready
  output logic [31:0]           s_axi_rdata,       // read data
  output logic [1:0]            s_axi_rresp,       // read response
  output logic                  s_axi_rvalid,      // read data valid
  input  wire logic             s_axi_rready,      // read data ready
  input  wire logic             conv_done_in,      // core done pulse
  input  wire logic [RES_W-1:0] conv_data_in,      // core result
  output logic                  conv_start_out,    // core start pulse
  output logic                  conv_clk_tick_out, // conversion clock tick
  output logic                  power_on_out,      // converter powered
  output logic [NPIN-1:0]       ext_input_sel_out, // one-hot external input, all zero while the sensor is picked
  output logic                  sel_tso_out,       // sensor output voltage
  output logic                  sel_tsvref_out,    // sensor reference voltage
  output logic                  temp_sensor_en_out,// sensor circuitry on
  output logic [NPIN-1:0]       pin_analog_out,    // pin digital path off
  output logic [NPIN-1:0]       pin_pullup_off_out,// pin pull-up removed
  output logic                  irq_out            // level interrupt
);
  // ==========================================================
  // registers
  logic [7:0]         ctrl_pri_reg, ctrl_sec_reg;
  logic [7:0]         ts_ref_reg, ts_en_reg, ts_clk_reg, ts_ins_reg;
  logic [NPIN-1:0]    pin_ana_reg;
  logic               irq_stat_reg, irq_mask_reg;
  logic [RES_W-1:0]   result_reg;
  logic               busy_reg;
  adcc_pkg::adcc_state_t state_reg, state_next;
  logic [7:0]         awaddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               aw_held_reg, w_held_reg;
  logic               tick_w;

  // ==========================================================
  // decode
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire ar_take   = s_axi_arvalid && s_axi_arready;
  wire wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_lane0  = wr_fire && wstrb_reg[0];
  wire wr_pri    = wr_lane0 && (awaddr_reg == `ADCC_OFF_CTRL_PRI);
  wire wr_sec    = wr_lane0 && (awaddr_reg == `ADCC_OFF_CTRL_SEC);
  wire wr_tsref  = wr_lane0 && (awaddr_reg == `ADCC_OFF_TS_REF);
  wire wr_tsen   = wr_lane0 && (awaddr_reg == `ADCC_OFF_TS_EN);
  wire wr_tsclk  = wr_lane0 && (awaddr_reg == `ADCC_OFF_TS_CLK);
  wire wr_tsins  = wr_lane0 && (awaddr_reg == `ADCC_OFF_TS_INSEL);
  wire wr_stat   = wr_lane0 && (awaddr_reg == `ADCC_OFF_IRQ_STAT);
  wire wr_mask   = wr_lane0 && (awaddr_reg == `ADCC_OFF_IRQ_MASK);
  wire wr_pin    = wr_lane0 && (awaddr_reg == `ADCC_OFF_PIN_ANA);
  wire wr_mapped = (awaddr_reg <= `ADCC_OFF_PIN_ANA) && (awaddr_reg[1:0] == 2'h0);
  wire rd_mapped = (s_axi_araddr <= `ADCC_OFF_PIN_ANA) && (s_axi_araddr[1:0] == 2'h0);

  wire [7:0] wbyte     = wdata_reg[7:0];
  wire       power_on  = ctrl_pri_reg[`ADCC_BIT_POWER];
  wire       justify   = ctrl_pri_reg[`ADCC_BIT_JUSTIFY];
  wire       src_top   = ctrl_pri_reg[`ADCC_BIT_SRC_TOP];
  wire [2:0] src_low   = ctrl_pri_reg[2:0];
  wire       auto_rep  = ctrl_sec_reg[`ADCC_BIT_AUTO];
  wire [2:0] clk_div   = ctrl_sec_reg[2:0];
  wire       ts_en     = ts_en_reg[`ADCC_BIT_TS_EN];
  wire       ref_out   = ts_ref_reg[`ADCC_BIT_REF_OUT];
  // start falls from high to low in a write: the complete low-high-low pulse
  wire start_fall = wr_pri && ctrl_pri_reg[`ADCC_BIT_START]
                    && !wbyte[`ADCC_BIT_START];

  // ==========================================================
  // result formatting; the raw value is cleared while powered off
  wire [7:0] res_high = justify ? {4'h0, result_reg[11:8]}
                                : result_reg[11:4];
  wire [7:0] res_low  = justify ? result_reg[7:0]
                                : {result_reg[3:0], 4'h0};
  wire [7:0] pri_view = {ctrl_pri_reg[7], busy_reg, ctrl_pri_reg[5:0]};

  // ==========================================================
  // analog source selection: exactly one source at all times
  wire             pick_ts   = ts_en && src_top;
  wire [NPIN-1:0]  ext_next;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_ext
      assign ext_next[gi] = !pick_ts && (src_low == 3'(gi));
    end
  endgenerate
  wire tso_next    = pick_ts && !ref_out;
  wire tsvref_next = pick_ts && ref_out;

  // ==========================================================
  // conversion sequencer
  wire done_now = (state_reg == adcc_pkg::ADCC_BUSY) && conv_done_in;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcc_pkg::ADCC_IDLE:   if (start_fall && power_on) state_next = adcc_pkg::ADCC_LAUNCH;
      adcc_pkg::ADCC_LAUNCH: state_next = adcc_pkg::ADCC_BUSY;
      adcc_pkg::ADCC_BUSY: begin
        if (!power_on) state_next = adcc_pkg::ADCC_IDLE;
        else if (conv_done_in) state_next = auto_rep ? adcc_pkg::ADCC_LAUNCH
                                                      : adcc_pkg::ADCC_IDLE;
      end
      default: state_next = adcc_pkg::ADCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg      <= adcc_pkg::ADCC_IDLE;
      busy_reg       <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      state_reg      <= state_next;
      conv_start_out <= (state_next == adcc_pkg::ADCC_LAUNCH);
      busy_reg       <= (state_next != adcc_pkg::ADCC_IDLE)
                        && !(done_now && !auto_rep);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_reg <= '0;
    end else if (!power_on) begin
      result_reg <= '0;
    end else if (done_now) begin
      result_reg <= conv_data_in;
    end
  end

  // ==========================================================
  // control registers; all reset to zero except ts_ref_reg, which resets to 8'h40
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_pri_reg <= `ADCC_RST_BYTE;
      ctrl_sec_reg <= `ADCC_RST_BYTE;
      ts_ref_reg   <= `ADCC_RST_TS_REF;
      ts_en_reg    <= `ADCC_RST_BYTE;
      ts_clk_reg   <= `ADCC_RST_BYTE;
      ts_ins_reg   <= `ADCC_RST_BYTE;
      pin_ana_reg  <= '0;
      irq_mask_reg <= 1'b0;
    end else begin
      if (wr_pri)   ctrl_pri_reg <= wbyte & `ADCC_WMASK_PRI;
      if (wr_sec)   ctrl_sec_reg <= wbyte & `ADCC_WMASK_SEC;
      if (wr_tsref) ts_ref_reg   <= wbyte & `ADCC_WMASK_TS_REF;
      if (wr_tsen)  ts_en_reg    <= wbyte & `ADCC_WMASK_TS_EN;
      if (wr_tsclk) ts_clk_reg   <= wbyte & `ADCC_WMASK_TS_CLK;
      if (wr_tsins) ts_ins_reg   <= wbyte & `ADCC_WMASK_TS_INS;
      if (wr_pin)   pin_ana_reg  <= wbyte[NPIN-1:0];
      if (wr_mask)  irq_mask_reg <= wbyte[0];
    end
  end

  // completion wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_stat_reg <= 1'b0;
      irq_out      <= 1'b0;
    end else begin
      irq_stat_reg <= done_now || (irq_stat_reg && !(wr_stat && wbyte[0]));
      irq_out      <= irq_stat_reg && irq_mask_reg;
    end
  end

  // ==========================================================
  // outputs to the analog side
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_on_out       <= 1'b0;
      ext_input_sel_out  <= NPIN'(1);
      sel_tso_out        <= 1'b0;
      sel_tsvref_out     <= 1'b0;
      temp_sensor_en_out <= 1'b0;
      pin_analog_out     <= '0;
      pin_pullup_off_out <= '0;
    end else begin
      power_on_out       <= power_on;
      ext_input_sel_out  <= ext_next;
      sel_tso_out        <= tso_next;
      sel_tsvref_out     <= tsvref_next;
      temp_sensor_en_out <= ts_en;
      pin_analog_out     <= pin_ana_reg;
      pin_pullup_off_out <= pin_ana_reg;
    end
  end

  adcc_clkdiv #(
    .SEL_W (3)
  ) u_div (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .run_in     (power_on),
    .sel_in     (clk_div),
    .tick_out   (tick_w)
  );

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) conv_clk_tick_out <= 1'b0;
    else            conv_clk_tick_out <= tick_w;
  end

  // ==========================================================
  // AXI4-Lite write path: one write at a time, address and data in any order
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_held_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_held_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path; result bytes are read-only, writes to them are ignored
  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      `ADCC_OFF_RES_LOW:  rd_byte = res_low;
      `ADCC_OFF_RES_HIGH: rd_byte = res_high;
      `ADCC_OFF_CTRL_PRI: rd_byte = pri_view;
      `ADCC_OFF_CTRL_SEC: rd_byte = ctrl_sec_reg;
      `ADCC_OFF_TS_REF:   rd_byte = ts_ref_reg;
      `ADCC_OFF_TS_EN:    rd_byte = ts_en_reg;
      `ADCC_OFF_TS_CLK:   rd_byte = ts_clk_reg;
      `ADCC_OFF_TS_INSEL: rd_byte = ts_ins_reg;
      `ADCC_OFF_IRQ_STAT: rd_byte = {7'h0, irq_stat_reg};
      `ADCC_OFF_IRQ_MASK: rd_byte = {7'h0, irq_mask_reg};
      `ADCC_OFF_PIN_ANA:  rd_byte = pin_ana_reg;
      default:            rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ADCC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h0, rd_byte};
      s_axi_rresp   <= rd_mapped ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // the raw result holds across the read edge when powered and not completing
  chk_left_justify: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (ar_take && !justify && power_on && !done_now && s_axi_araddr == `ADCC_OFF_RES_HIGH)
    |=> (s_axi_rdata == {24'h0, result_reg[11:4]}))
    else $error("left justified layout wrong");
  chk_right_justify: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (ar_take && justify && power_on && !done_now && s_axi_araddr == `ADCC_OFF_RES_LOW)
    |=> (s_axi_rdata == {24'h0, result_reg[7:0]}))
    else $error("right justified layout wrong");
  chk_result_off_zero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !power_on |=> (result_reg == '0))
    else $error("result not cleared while off");
  chk_src_ext_route: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !ts_en |=> ext_input_sel_out[$past(src_low)])
    else $error("external input not routed");
  chk_src_ts_route: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (ts_en && src_top && !ref_out) |=> (sel_tso_out && !sel_tsvref_out))
    else $error("sensor output not routed");
  chk_src_ref_route: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (ts_en && src_top && ref_out) |=> (sel_tsvref_out && !sel_tso_out))
    else $error("sensor reference not routed");
  chk_src_onehot: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $onehot({ext_input_sel_out, sel_tso_out, sel_tsvref_out}))
    else $error("analog sources not exactly one");
  chk_start_busy: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (start_fall && power_on && !busy_reg) |=> (busy_reg && conv_start_out))
    else $error("start pulse did not launch");
  chk_done_irq: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done_now && !auto_rep && power_on) |=> (!busy_reg && irq_stat_reg
                                             && result_reg == $past(conv_data_in)))
    else $error("completion effects not together");
  chk_auto_again: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (done_now && auto_rep && power_on) |=> conv_start_out ##1 busy_reg)
    else $error("auto repeat did not restart");
endmodule : adcc_top
`default_nettype wire

//--- bench/adcc_core_model.sv
/*
  conversion core model: answers each start pulse with a done pulse.
  assumes: start and done share the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input  wire logic        clk_sys_in, // system clock
  input  wire logic        resetn_in,  // async reset, active low
  input  wire logic        start_in,   // start pulse
  input  wire logic [7:0]  lat_in,     // cycles until done
  input  wire logic [11:0] val_in,     // result to hand back
  output logic             done_out,   // one-cycle done
  output logic [11:0]      data_out    // result, valid with done
);
  logic [7:0] cnt_reg;
  logic       run_reg;
  // ==========================================================
  // data flips outside done so a stale capture shows up
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg  <= 8'h00;
      run_reg  <= 1'b0;
      done_out <= 1'b0;
      data_out <= 12'h000;
    end else begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (start_in) begin
        run_reg <= 1'b1;
        cnt_reg <= lat_in;
      end else if (run_reg && cnt_reg == 8'h00) begin
        run_reg  <= 1'b0;
        done_out <= 1'b1;
        data_out <= val_in;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : adcc_core_model
`default_nettype wire

//--- bench/adc_control_result_regs_test.sv
/*
  self-checking bench for the converter control block.
  assumes: core model on the far side; AXI4-Lite master in here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module adc_control_result_regs_test;
  logic        clk_sys_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, lat, r, ext, pana, pup;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, done, start, tick, pwr;
  logic        tso, tsv, tsen, irq;
  logic [1:0]  bresp, rresp;
  logic [11:0] cdata, val, v;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total, cmp_count, n, k, starts;
  adcc_top uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done_in(done), .conv_data_in(cdata), .conv_start_out(start),
    .conv_clk_tick_out(tick), .power_on_out(pwr), .ext_input_sel_out(ext),
    .sel_tso_out(tso), .sel_tsvref_out(tsv), .temp_sensor_en_out(tsen),
    .pin_analog_out(pana), .pin_pullup_off_out(pup), .irq_out(irq));
  adcc_core_model cm (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .start_in(start),
    .lat_in(lat), .val_in(val), .done_out(done), .data_out(cdata));
  // ==========================================================
  // helpers
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge clk_sys_in);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk_sys_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : settle
  // ==========================================================
  // clock, response checker, watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (start) starts++;
  end
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    {resetn_in, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {err_total, cmp_count, starts} = '0;
    lat = 8'h14;
    val = 12'h000;
    void'($urandom(32'hCB83D757));
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(`ADCC_OFF_CTRL_PRI, 34'h0);
    rd(`ADCC_OFF_TS_REF, 34'h40);
    rd(8'h2C, {2'h2, 32'h0});
    wr(8'h2C, 8'hFF, `ADCC_RESP_SLVERR);
    wr(`ADCC_OFF_TS_CLK, 8'hFF, `ADCC_RESP_OKAY);
    rd(`ADCC_OFF_TS_CLK, 34'hC3);
    r = $urandom;
    wr(`ADCC_OFF_PIN_ANA, r, `ADCC_RESP_OKAY);
    settle();
    chk({pana, pup}, {r, r});
    for (k = 0; k < 8; k++) begin
      r = $urandom_range(15, 0);
      wr(`ADCC_OFF_CTRL_PRI, 8'h20 | r, `ADCC_RESP_OKAY);
      settle();
      chk(ext, 8'h01 << r[2:0]);
      chk({tso, tsv, pwr}, 3'b001);
    end
    wr(`ADCC_OFF_TS_EN, 8'h80, `ADCC_RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      wr(`ADCC_OFF_TS_REF, k ? 8'h80 : 8'h00, `ADCC_RESP_OKAY);
      wr(`ADCC_OFF_CTRL_PRI, 8'h28, `ADCC_RESP_OKAY);
      settle();
      chk({tsen, ext, tso, tsv}, {1'b1, 8'h00, k == 0, k == 1});
    end
    wr(`ADCC_OFF_TS_EN, 8'h00, `ADCC_RESP_OKAY);
    for (k = 0; k < 8; k++) begin
      wr(`ADCC_OFF_CTRL_SEC, k, `ADCC_RESP_OKAY);
      repeat (2) do @(posedge clk_sys_in); while (!tick);
      n = 0;
      do begin
        @(posedge clk_sys_in);
        n++;
      end while (!tick);
      chk(n, 1 << k);
    end
    wr(`ADCC_OFF_CTRL_SEC, 8'h00, `ADCC_RESP_OKAY);
    wr(`ADCC_OFF_IRQ_MASK, 8'h01, `ADCC_RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      v = $urandom;
      val = v;
      wr(`ADCC_OFF_CTRL_PRI, 8'hA0 | (k << 4), `ADCC_RESP_OKAY);
      wr(`ADCC_OFF_CTRL_PRI, 8'h20 | (k << 4), `ADCC_RESP_OKAY);
      @(posedge clk_sys_in);
      chk(starts, k + 1);
      rd(`ADCC_OFF_CTRL_PRI, 8'h60 | (k << 4));
      do @(posedge clk_sys_in); while (!done);
      settle();
      chk(irq, 1'b1);
      rd(`ADCC_OFF_IRQ_STAT, 34'h1);
      rd(`ADCC_OFF_RES_LOW, k ? v[7:0] : {v[3:0], 4'h0});
      rd(`ADCC_OFF_RES_HIGH, k ? {4'h0, v[11:8]} : v[11:4]);
      rd(`ADCC_OFF_CTRL_PRI, 8'h20 | (k << 4));
      wr(`ADCC_OFF_IRQ_STAT, 8'h01, `ADCC_RESP_OKAY);
      settle();
      chk(irq, 1'b0);
    end
    wr(`ADCC_OFF_RES_HIGH, 8'hFF, `ADCC_RESP_OKAY);
    rd(`ADCC_OFF_RES_HIGH, {4'h0, v[11:8]});
    wr(`ADCC_OFF_CTRL_SEC, 8'h80, `ADCC_RESP_OKAY);
    wr(`ADCC_OFF_CTRL_PRI, 8'hA0, `ADCC_RESP_OKAY);
    wr(`ADCC_OFF_CTRL_PRI, 8'h20, `ADCC_RESP_OKAY);
    n = 0;
    repeat (100) begin
      @(posedge clk_sys_in);
      if (start) n++;
    end
    chk(n >= 3, 1'b1);
    do @(posedge clk_sys_in); while (!irq);
    rd(`ADCC_OFF_RES_HIGH, v[11:4]);
    wr(`ADCC_OFF_CTRL_SEC, 8'h00, `ADCC_RESP_OKAY);
    wr(`ADCC_OFF_CTRL_PRI, 8'h00, `ADCC_RESP_OKAY);
    settle();
    chk(pwr, 1'b0);
    rd(`ADCC_OFF_RES_LOW, 34'h0);
    rd(`ADCC_OFF_RES_HIGH, 34'h0);
    settle();
    print_verdict();
  end
endmodule : adc_control_result_regs_test
`default_nettype wire
